// ===== logic/i2c_device_end.sv
// Contract
// - Bytes are eight bits, MSB first
// - Receiver acknowledges in the ninth clock
// - SDA edges during SCL high: start, stop
// - Data changes only while SCL is low
// - Host opens with start plus address byte
// - Device answers seven-bit address 0x5A
// - Acknowledge holds SDA low whole slot
// - SDA only pulled low or released
// - Any byte count between start, stop
// - Write: direction 0, register byte acknowledged
// - Write data goes to consecutive registers
// - Every written data byte is acknowledged
// - Read: set address, repeated start, read
// - Read bytes advance while host acknowledges
// - Host acknowledges all but last byte
// - All registers reachable single or sequential
// - Device also answers broadcast address 0x58, for writes only
`include "i2c_link_cfg.svh"

module i2c_device_end (
  input  wire logic            clk_i,     // Register file clock
  input  wire logic            reset_i,   // Asynchronous reset
  i2c_link_if.device           bus,       // Serial link
  output logic                 wr_en_o,   // Register write strobe
  output i2c_link_pkg::byte_t  wr_addr_o, // Register write address
  output i2c_link_pkg::byte_t  wr_data_o, // Register write data
  output i2c_link_pkg::byte_t  rd_addr_o, // Register read address
  input  wire i2c_link_pkg::byte_t rd_data_i  // Register read data
);

  // Clock domain: pin synchronisers and condition detection.
  logic        scl_s1;
  logic        scl_s2;
  logic        sda_s1;
  logic        sda_s2;
  logic        sda_s3;
  logic [2:0]  cond_cnt;
  logic        cond_rst;
  logic        link_rst;
  logic [1:0]  tgl_s1;
  logic [1:0]  tgl_s2;
  logic [1:0]  tgl_s3;
  i2c_link_pkg::byte_t rd_hold;

  // Link domain.
  i2c_link_pkg::dev_state_t state;
  i2c_link_pkg::dev_state_t next_state;
  logic [3:0]  cnt;
  i2c_link_pkg::byte_t shift;
  i2c_link_pkg::byte_t tx;
  logic        ack_flag;
  logic        next_ack;
  logic        sda_oe;
  i2c_link_pkg::byte_t ptr;
  i2c_link_pkg::byte_t wr_addr_l;
  i2c_link_pkg::byte_t wr_data_l;
  logic [1:0]  tgl_l;

  wire start_det = scl_s2 & sda_s3 & ~sda_s2;
  wire stop_det  = scl_s2 & ~sda_s3 & sda_s2;
  wire cond_det  = start_det | stop_det;
  wire [2:0] next_cond_cnt = cond_det ? `I2C_COND_RST_CYCLES :
                             (cond_cnt != 3'h0) ? cond_cnt - 3'h1 : 3'h0;
  wire wr_pulse  = tgl_s2[0] ^ tgl_s3[0];
  wire ptr_pulse = tgl_s2[1] ^ tgl_s3[1];

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      cond_cnt <= 3'h0;
      cond_rst <= 1'b0;
    end else begin
      scl_s1 <= bus.scl;
      scl_s2 <= scl_s1;
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      cond_cnt <= next_cond_cnt;
      cond_rst <= (next_cond_cnt != 3'h0);
    end
  end

  // The serial clock stops after a stop, so a condition cannot be handed
  // to the link logic as an event; it is applied as an asynchronous reset
  // that the host's low phase releases before the next rising edge.
  assign link_rst = reset_i | cond_rst;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tgl_s1 <= 2'h0;
      tgl_s2 <= 2'h0;
      tgl_s3 <= 2'h0;
      wr_en_o <= 1'b0;
      wr_addr_o <= 8'h00;
      wr_data_o <= 8'h00;
      rd_addr_o <= 8'h00;
      rd_hold <= 8'h00;
    end else begin
      tgl_s1 <= tgl_l;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
      wr_en_o <= wr_pulse;
      rd_hold <= rd_data_i;
      if (wr_pulse) begin
        wr_addr_o <= wr_addr_l;
        wr_data_o <= wr_data_l;
      end
      if (ptr_pulse) begin
        rd_addr_o <= ptr;
      end
    end
  end

  // Link-side decode.
  wire [7:0] rx_byte  = {shift[6:0], bus.sda};
  wire       byte_end = (cnt == `I2C_LAST_BIT);
  wire       ack_slot = (cnt == `I2C_ACK_SLOT);
  wire       own_hit  = (rx_byte[7:1] == `I2C_OWN_ADDR);
  // Broadcast is write-only: a read would make every driver answer at once.
  wire       bcast_hit = (rx_byte[7:1] == `I2C_BCAST_ADDR) &
                         (rx_byte[0] == `I2C_RW_WRITE);
  wire       reg_end  = byte_end & (state == i2c_link_pkg::DEV_REG);
  wire       data_end = byte_end & (state == i2c_link_pkg::DEV_WDATA);
  // The device acknowledges its own read address, so that slot must not
  // move the pointer; only the host's acknowledge after a data byte does.
  wire       rd_acked = ack_slot & (state == i2c_link_pkg::DEV_RDATA) &
                        ~ack_flag & ~bus.sda;

  always_comb begin
    next_state = state;
    next_ack = 1'b0;
    if (byte_end) begin
      case (state)
        i2c_link_pkg::DEV_ADDR: begin
          if (own_hit | bcast_hit) begin
            next_ack = 1'b1;
            next_state = (rx_byte[0] == `I2C_RW_READ) ?
                         i2c_link_pkg::DEV_RDATA :
                         i2c_link_pkg::DEV_REG;
          end else begin
            next_state = i2c_link_pkg::DEV_IGNORE;
          end
        end
        i2c_link_pkg::DEV_REG: begin
          next_ack = 1'b1;
          next_state = i2c_link_pkg::DEV_WDATA;
        end
        i2c_link_pkg::DEV_WDATA: begin
          next_ack = 1'b1;
        end
        default: begin
          next_state = state;
        end
      endcase
    end else if (ack_slot && state == i2c_link_pkg::DEV_RDATA && bus.sda) begin
      // A not-acknowledge ends the read; the host follows with a stop.
      next_state = i2c_link_pkg::DEV_IGNORE;
    end
  end

  always_ff @(posedge bus.scl or posedge link_rst) begin
    if (link_rst) begin
      state <= i2c_link_pkg::DEV_ADDR;
      cnt <= 4'h0;
      shift <= 8'h00;
      ack_flag <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= ack_slot ? 4'h0 : cnt + 4'h1;
      shift <= rx_byte;
      ack_flag <= next_ack;
    end
  end

  // Pointer and write hand-off survive a start, so a repeated start
  // reads from the register that the preceding write selected.
  always_ff @(posedge bus.scl or posedge reset_i) begin
    if (reset_i) begin
      ptr <= 8'h00;
      wr_addr_l <= 8'h00;
      wr_data_l <= 8'h00;
      tgl_l <= 2'h0;
    end else begin
      if (reg_end) begin
        ptr <= rx_byte;
        tgl_l[1] <= ~tgl_l[1];
      end else if (data_end) begin
        wr_addr_l <= ptr;
        wr_data_l <= rx_byte;
        tgl_l[0] <= ~tgl_l[0];
        ptr <= ptr + 8'h01;
        tgl_l[1] <= ~tgl_l[1];
      end else if (rd_acked) begin
        ptr <= ptr + 8'h01;
        tgl_l[1] <= ~tgl_l[1];
      end
    end
  end

  // Outgoing bits move on the falling edge, so they settle in the low
  // phase. rd_hold is sampled half a serial period after the pointer
  // moved, long after the clock domain has refreshed it.
  always_ff @(negedge bus.scl or posedge link_rst) begin
    if (link_rst) begin
      sda_oe <= 1'b0;
      tx <= 8'h00;
    end else if (cnt == `I2C_ACK_SLOT) begin
      sda_oe <= ack_flag;
      tx <= tx;
    end else if (state == i2c_link_pkg::DEV_RDATA) begin
      if (cnt == 4'h0) begin
        sda_oe <= ~rd_hold[7];
        tx <= {rd_hold[6:0], 1'b0};
      end else begin
        sda_oe <= ~tx[7];
        tx <= {tx[6:0], 1'b0};
      end
    end else begin
      sda_oe <= 1'b0;
      tx <= tx;
    end
  end

  assign bus.dev_sda_oe = sda_oe;
  assign bus.dev_sda_o  = 1'b0;

endmodule

// ===== logic/i2c_host_end.sv
`include "i2c_link_cfg.svh"

module i2c_link_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic         clk_i,       // Clock
  input  wire logic         reset_i,     // Asynchronous reset
  input  wire logic         in_valid_i,  // Fill side valid
  input  wire logic [W-1:0] in_data_i,   // Fill side data
  output logic              in_ready_o,  // Fill side ready
  output logic              out_valid_o, // Drain side valid
  output logic [W-1:0]      out_data_o,  // Drain side data
  input  wire logic         out_ready_i  // Drain side ready
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;

  wire          push = in_valid_i & in_ready_o;
  wire          pop  = out_valid_o & out_ready_i;
  wire [AW:0]   next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  assign out_data_o = mem[rd_ptr];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count <= next_count;
      in_ready_o <= (next_count != (AW+1)'(DEPTH));
      out_valid_o <= (next_count != '0);
    end
  end
endmodule

module i2c_host_end (
  input  wire logic            clk_i,      // Clock
  input  wire logic            reset_i,    // Asynchronous reset
  i2c_link_if.host             bus,        // Serial link
  input  wire logic            go_i,       // Start a transfer, pulse
  input  wire logic            read_i,     // 1 read, 0 write
  input  wire logic [6:0]      dev_addr_i, // Target bus address
  input  wire i2c_link_pkg::byte_t reg_addr_i, // Start register
  input  wire i2c_link_pkg::byte_t rd_len_i,   // Bytes to read
  input  wire logic            wd_valid_i, // Write data valid
  input  wire i2c_link_pkg::byte_t wd_data_i,  // Write data
  output logic                 wd_ready_o, // Write data ready
  output logic                 rd_valid_o, // Read byte strobe
  output i2c_link_pkg::byte_t  rd_data_o,  // Read byte
  output logic                 busy_o,     // Transfer running
  output logic                 nack_o      // Last transfer refused
);
  localparam logic [7:0] QUARTER = 8'(`I2C_QUARTER_CYCLES);

  i2c_link_pkg::host_state_t state;
  i2c_link_pkg::host_step_t  step;
  logic [7:0]  tick_cnt;
  logic [1:0]  q;
  logic [3:0]  bitn;
  logic        scl;
  logic        sda_oe;
  logic        sda_s1;
  logic        sda_s2;
  logic        rw;
  logic [6:0]  dev;
  i2c_link_pkg::byte_t regb;
  i2c_link_pkg::byte_t remain;
  i2c_link_pkg::byte_t txb;
  i2c_link_pkg::byte_t rxb;
  logic        f_valid;
  i2c_link_pkg::byte_t f_data;

  wire tick     = (tick_cnt == QUARTER - 8'h01);
  wire drive_pt = tick & (q == 2'h0);
  wire end_pt   = tick & (q == 2'h3);
  wire last     = (remain == 8'h01);
  wire want_wd  = (step == i2c_link_pkg::STEP_DATA) |
                  ((step == i2c_link_pkg::STEP_REG) & ~rw);
  wire f_pop    = (state == i2c_link_pkg::HOST_TX) & end_pt &
                  (bitn == `I2C_ACK_SLOT) & ~sda_s2 & want_wd & f_valid;

  // Back-pressure: the bus drains one byte per nine serial clocks.
  i2c_link_fifo #(.W(`I2C_BYTE_W), .DEPTH(`I2C_FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (wd_valid_i),
    .in_data_i   (wd_data_i),
    .in_ready_o  (wd_ready_o),
    .out_valid_o (f_valid),
    .out_data_o  (f_data),
    .out_ready_i (f_pop)
  );

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= i2c_link_pkg::HOST_IDLE;
      step <= i2c_link_pkg::STEP_ADDR_W;
      tick_cnt <= 8'h00;
      q <= 2'h0;
      bitn <= 4'h0;
      scl <= 1'b1;
      sda_oe <= 1'b0;
      rw <= 1'b0;
      dev <= 7'h00;
      regb <= 8'h00;
      remain <= 8'h00;
      txb <= 8'h00;
      rxb <= 8'h00;
      rd_valid_o <= 1'b0;
      rd_data_o <= 8'h00;
      busy_o <= 1'b0;
      nack_o <= 1'b0;
    end else begin
      rd_valid_o <= 1'b0;
      if (state == i2c_link_pkg::HOST_IDLE) begin
        tick_cnt <= 8'h00;
        q <= 2'h0;
        scl <= 1'b1;
        if (go_i) begin
          state <= i2c_link_pkg::HOST_START;
          step <= i2c_link_pkg::STEP_ADDR_W;
          rw <= read_i;
          dev <= dev_addr_i;
          regb <= reg_addr_i;
          remain <= (rd_len_i == 8'h00) ? 8'h01 : rd_len_i;
          busy_o <= 1'b1;
          nack_o <= 1'b0;
          scl <= 1'b0;
        end
      end else begin
        tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01;
        if (tick) begin
          q <= q + 2'h1;
          scl <= q[0] ^ q[1];
        end
        case (state)
          i2c_link_pkg::HOST_START: begin
            if (drive_pt) begin
              sda_oe <= 1'b0;
            end
            if (tick && q == 2'h2) begin
              sda_oe <= 1'b1;
            end
            if (end_pt) begin
              state <= i2c_link_pkg::HOST_TX;
              bitn <= 4'h0;
              txb <= {dev, (step == i2c_link_pkg::STEP_ADDR_R) ?
                      `I2C_RW_READ : `I2C_RW_WRITE};
            end
          end
          i2c_link_pkg::HOST_TX: begin
            if (drive_pt) begin
              // Released in the acknowledge slot; only ever pulls low.
              sda_oe <= (bitn != `I2C_ACK_SLOT) & ~txb[7];
            end
            if (end_pt && bitn != `I2C_ACK_SLOT) begin
              bitn <= bitn + 4'h1;
              txb <= {txb[6:0], 1'b0};
            end else if (end_pt) begin
              bitn <= 4'h0;
              if (sda_s2) begin
                nack_o <= 1'b1;
                state <= i2c_link_pkg::HOST_STOP;
              end else if (step == i2c_link_pkg::STEP_ADDR_W) begin
                txb <= regb;
                step <= i2c_link_pkg::STEP_REG;
              end else if (step == i2c_link_pkg::STEP_ADDR_R) begin
                state <= i2c_link_pkg::HOST_RX;
              end else if (rw) begin
                state <= i2c_link_pkg::HOST_START;
                step <= i2c_link_pkg::STEP_ADDR_R;
              end else if (f_valid) begin
                txb <= f_data;
                step <= i2c_link_pkg::STEP_DATA;
              end else begin
                state <= i2c_link_pkg::HOST_STOP;
              end
            end
          end
          i2c_link_pkg::HOST_RX: begin
            if (drive_pt) begin
              sda_oe <= (bitn == `I2C_ACK_SLOT) & ~last;
            end
            if (end_pt && bitn != `I2C_ACK_SLOT) begin
              bitn <= bitn + 4'h1;
              rxb <= {rxb[6:0], sda_s2};
              if (bitn == `I2C_LAST_BIT) begin
                rd_valid_o <= 1'b1;
                rd_data_o <= {rxb[6:0], sda_s2};
              end
            end else if (end_pt) begin
              bitn <= 4'h0;
              remain <= remain - 8'h01;
              if (last) begin
                state <= i2c_link_pkg::HOST_STOP;
              end
            end
          end
          i2c_link_pkg::HOST_STOP: begin
            if (drive_pt) begin
              sda_oe <= 1'b1;
            end
            if (tick && q == 2'h2) begin
              sda_oe <= 1'b0;
            end
            if (end_pt) begin
              state <= i2c_link_pkg::HOST_IDLE;
              busy_o <= 1'b0;
              scl <= 1'b1;
            end
          end
          default: begin
            state <= i2c_link_pkg::HOST_IDLE;
          end
        endcase
      end
    end
  end

  assign bus.scl = scl;
  assign bus.host_sda_oe = sda_oe;
  assign bus.host_sda_o  = 1'b0;

endmodule

// ===== logic/i2c_link_cfg.svh
`ifndef I2C_LINK_CFG_SVH
`define I2C_LINK_CFG_SVH

// Bus addresses answered by the device end.
`define I2C_OWN_ADDR   7'h5A
`define I2C_BCAST_ADDR 7'h58

// Direction bit values.
`define I2C_RW_WRITE 1'b0
`define I2C_RW_READ  1'b1

// Bit slots within one nine-clock byte frame.
`define I2C_LAST_BIT 4'h7
`define I2C_ACK_SLOT 4'h8

// Timing of the host-made serial clock.
`define I2C_CLK_PERIOD_PS  4000
`define I2C_SCL_PERIOD_PS  256000
`define I2C_QUARTER_CYCLES ((`I2C_SCL_PERIOD_PS) / (4 * `I2C_CLK_PERIOD_PS))

// Clock cycles for which a start or stop resets the link logic.
`define I2C_COND_RST_CYCLES 3'h4

// Write data buffer.
`define I2C_BYTE_W     8
`define I2C_FIFO_DEPTH 4

`endif

// ===== logic/i2c_link_if.sv
interface i2c_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // Wired-AND with a pull-up: the line is high unless a party pulls it low.
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host (output scl, host_sda_o, host_sda_oe, input sda);
  modport device (input scl, sda, output dev_sda_o, dev_sda_oe);
endinterface

// ===== logic/i2c_link_pkg.sv
package i2c_link_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [2:0] {
    DEV_ADDR   = 3'h0,
    DEV_REG    = 3'h1,
    DEV_WDATA  = 3'h3,
    DEV_RDATA  = 3'h2,
    DEV_IGNORE = 3'h6
  } dev_state_t;

  typedef enum logic [2:0] {
    HOST_IDLE  = 3'h0,
    HOST_START = 3'h1,
    HOST_TX    = 3'h3,
    HOST_RX    = 3'h2,
    HOST_STOP  = 3'h6
  } host_state_t;

  typedef enum logic [1:0] {
    STEP_ADDR_W = 2'h0,
    STEP_REG    = 2'h1,
    STEP_DATA   = 2'h3,
    STEP_ADDR_R = 2'h2
  } host_step_t;

endpackage

// ===== tb/i2c_link_checker.sv
module i2c_link_checker (
  input wire logic clk_i,       // Host clock
  input wire logic reset_i,     // Asynchronous reset
  input wire logic scl,         // Serial clock
  input wire logic host_sda_o,  // Host data value
  input wire logic host_sda_oe, // Host pulls data low
  input wire logic dev_sda_o,   // Device data value
  input wire logic dev_sda_oe,  // Device pulls data low
  input wire logic sda          // Resolved data line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bitn;
  logic [7:0] first;
  logic       first_done;
  wire start_w = scl && scl_q && sda_q && !sda;
  wire stop_w  = scl && scl_q && !sda_q && sda;
  wire rise_w  = scl && !scl_q;
  wire hit_w   = (first == 8'hB4) || (first == 8'hB5) || (first == 8'hB0);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // Every start reframes, so a repeated start is tracked like a fresh one.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bitn       <= 4'h0;
      first      <= 8'h00;
      first_done <= 1'b0;
    end else if (start_w) begin
      bitn       <= 4'h0;
      first_done <= 1'b0;
    end else if (rise_w) begin
      bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
      if (bitn == 4'h8) begin
        first_done <= 1'b1;
      end
      if (!first_done && bitn != 4'h8) begin
        first <= {first[6:0], sda};
      end
    end
  end

  sequence ack_slot;
    rise_w && bitn == 4'h8;
  endsequence
  sequence addr_done;
    ack_slot ##0 !first_done;
  endsequence

  chk_dev_pull_only: assert property (
    @(posedge clk_i) disable iff (reset_i) dev_sda_oe |-> !dev_sda_o)
    else $error("Device drives the data line high.");
  chk_host_pull_only: assert property (
    @(posedge clk_i) disable iff (reset_i) host_sda_oe |-> !host_sda_o)
    else $error("Host drives the data line high.");
  chk_dev_edge_low: assert property (
    @(posedge clk_i) disable iff (reset_i) $changed(dev_sda_oe) |-> !scl)
    else $error("Device changed data while the clock was high.");
  chk_host_edge_hold: assert property (
    @(posedge clk_i) disable iff (reset_i)
    scl && $changed(host_sda_oe) |-> scl [*8])
    else $error("Host data edge in clock high was not a condition.");
  chk_addr_ack: assert property (
    @(posedge clk_i) disable iff (reset_i) addr_done ##0 hit_w |-> !sda)
    else $error("Own address byte was not acknowledged.");
  chk_write_ack: assert property (
    @(posedge clk_i) disable iff (reset_i)
    ack_slot ##0 (first_done && hit_w && !first[0]) |-> !sda)
    else $error("Written byte was not acknowledged.");
  chk_foreign_nack: assert property (
    @(posedge clk_i) disable iff (reset_i) addr_done ##0 !hit_w |-> sda)
    else $error("Foreign address byte was acknowledged.");
  chk_foreign_quiet: assert property (
    @(posedge clk_i) disable iff (reset_i)
    first_done && !hit_w |-> !dev_sda_oe)
    else $error("Device pulled data after a foreign address.");
  chk_cond_release: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (start_w || stop_w) |-> ##[0:16] !dev_sda_oe)
    else $error("Device kept data low after a condition.");
endmodule

// ===== tb/i2c_slave_register_port_bench.sv
module i2c_slave_register_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk_i;
  logic                link_clk;
  logic                reset_i;
  logic                go;
  logic                read;
  logic [6:0]          dev_addr;
  i2c_link_pkg::byte_t reg_addr;
  i2c_link_pkg::byte_t rd_len;
  logic                wd_valid;
  i2c_link_pkg::byte_t wd_data;
  logic                wd_ready;
  logic                rd_valid;
  i2c_link_pkg::byte_t rd_data;
  logic                busy;
  logic                nack;
  logic                wr_en;
  i2c_link_pkg::byte_t wr_addr;
  i2c_link_pkg::byte_t wr_data;
  i2c_link_pkg::byte_t rd_addr;
  i2c_link_pkg::byte_t regfile [256];
  i2c_link_pkg::byte_t shadow [256];
  logic [15:0]         wq [$];
  i2c_link_pkg::byte_t rq [$];
  logic [15:0]         exp_w;
  i2c_link_pkg::byte_t exp_r;
  logic [31:0]         seed;
  int                  fails;
  int                  num_checks;
  int                  cycles;

  i2c_link_if link ();
  i2c_link_if link2 ();
  i2c_host_end i2c_host_end_i (.clk_i(clk_i), .reset_i(reset_i), .bus(link),
    .go_i(go), .read_i(read), .dev_addr_i(dev_addr), .reg_addr_i(reg_addr),
    .rd_len_i(rd_len), .wd_valid_i(wd_valid), .wd_data_i(wd_data),
    .wd_ready_o(wd_ready), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
    .busy_o(busy), .nack_o(nack));
  i2c_device_end i2c_device_end_i (.clk_i(link_clk), .reset_i(reset_i),
    .bus(link), .wr_en_o(wr_en), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
    .rd_addr_o(rd_addr), .rd_data_i(regfile[rd_addr]));
  // Second device faces a bench driver that aborts bytes on purpose.
  i2c_device_end i2c_device_end_i2 (.clk_i(link_clk), .reset_i(reset_i),
    .bus(link2), .wr_en_o(), .wr_addr_o(), .wr_data_o(), .rd_addr_o(),
    .rd_data_i(8'h00));
  i2c_link_checker i2c_link_checker_i (.clk_i(clk_i), .reset_i(reset_i),
    .scl(link.scl), .host_sda_o(link.host_sda_o),
    .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o),
    .dev_sda_oe(link.dev_sda_oe), .sda(link.sda));

  always #2 clk_i = ~clk_i;
  always begin
    #1.7;
    forever #6 link_clk = ~link_clk;
  end

  task automatic conclude();
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_byte(input i2c_link_pkg::byte_t got,
                          input i2c_link_pkg::byte_t exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // The register file behind the device; strobes are checked against notes.
  always @(posedge link_clk) begin
    if (wr_en === 1'b1) begin
      regfile[wr_addr] <= wr_data;
      exp_w = (wq.size() > 0) ? wq.pop_front() : 16'hxxxx;
      chk_byte(wr_addr, exp_w[15:8], "write address");
      chk_byte(wr_data, exp_w[7:0], "write data");
    end
  end

  always @(posedge clk_i) begin
    if (rd_valid === 1'b1) begin
      exp_r = (rq.size() > 0) ? rq.pop_front() : 8'hxx;
      chk_byte(rd_data, exp_r, "read byte");
    end
  end

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      fails++;
      $display("CHECK FAILED %0t run hung", $time);
      conclude();
    end
  end

  task automatic push_byte(input i2c_link_pkg::byte_t d, output logic ok);
    @(negedge clk_i);
    wd_valid = 1'b1;
    wd_data  = d;
    ok       = wd_ready;
    @(negedge clk_i);
    wd_valid = 1'b0;
  endtask

  task automatic xfer(input logic [6:0] dev, input logic rd,
                      input i2c_link_pkg::byte_t ra, input int n,
                      input i2c_link_pkg::byte_t len);
    logic                hit;
    logic                ok;
    logic [31:0]         r;
    hit = (dev == 7'h5A) || (dev == 7'h58 && !rd);
    for (int i = 0; i < n; i++) begin
      r = xs();
      if (rd) begin
        rq.push_back(shadow[ra + i[7:0]]);
      end else begin
        push_byte(r[7:0], ok);
        chk_bit(ok, 1'b1, "buffer ready");
        shadow[ra + i[7:0]] = r[7:0];
        wq.push_back({ra + i[7:0], r[7:0]});
      end
    end
    @(negedge clk_i);
    go       = 1'b1;
    read     = rd;
    dev_addr = dev;
    reg_addr = ra;
    rd_len   = len;
    @(negedge clk_i);
    go = 1'b0;
    chk_bit(busy, 1'b1, "busy");
    for (int k = 0; k < 20000 && busy !== 1'b0; k++) @(negedge clk_i);
    chk_bit(busy, 1'b0, "busy stuck");
    chk_bit(nack, !hit, "refusal");
  endtask

  task automatic bit2(input logic b, input logic ack);
    link2.scl = 1'b0;
    #32 link2.host_sda_oe = !b;
    #96 link2.scl = 1'b1;
    #64 if (ack) chk_bit(link2.sda, 1'b0, "ack after abort");
    #64;
  endtask

  // A start when low is set, a stop otherwise.
  task automatic cond2(input logic to_low);
    link2.scl = 1'b0;
    #32 link2.host_sda_oe = !to_low;
    #96 link2.scl = 1'b1;
    #64 link2.host_sda_oe = to_low;
    #64;
  endtask

  task automatic addr2();
    logic [7:0] a;
    a = 8'hB4;
    for (int i = 7; i >= 0; i--) bit2(a[i], 1'b0);
    bit2(1'b1, 1'b1);
  endtask

  initial begin
    logic [31:0]         r;
    logic                ok;
    logic [6:0]          da;
    int                  n;
    clk_i = 1'b0;
    link_clk = 1'b0;
    reset_i = 1'b1;
    {go, read, dev_addr, reg_addr, rd_len, wd_valid, wd_data} = '0;
    seed = 32'h5ce9_c99a;
    {fails, num_checks, cycles} = '0;
    {link2.scl, link2.host_sda_o, link2.host_sda_oe} = 3'b100;
    for (int i = 0; i < 256; i++) begin
      r = xs();
      regfile[i] = r[7:0];
      shadow[i] = r[7:0];
    end
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    // Overfill the buffer, then stream it across the pointer wrap.
    for (int i = 0; i < 5; i++) begin
      r = xs();
      push_byte(r[7:0], ok);
      chk_bit(ok, i < 4, "buffer full");
      if (i < 4) begin
        shadow[8'hFE + i[7:0]] = r[7:0];
        wq.push_back({8'hFE + i[7:0], r[7:0]});
      end
    end
    xfer(7'h5A, 1'b0, 8'hFE, 0, 8'h00);
    xfer(7'h5A, 1'b1, 8'hFE, 4, 8'h04);
    xfer(7'h5B, 1'b0, 8'h10, 0, 8'h01);
    xfer(7'h58, 1'b1, 8'h10, 0, 8'h01);
    xfer(7'h58, 1'b0, 8'h20, 2, 8'h00);
    for (int k = 0; k < 10; k++) begin
      r = xs();
      da = (r[1:0] == 2'h3) ? r[12:6] : (r[1:0] == 2'h2 ? 7'h58 : 7'h5A);
      n = 1 + int'(r[5:4]);
      if (!(da == 7'h5A || (da == 7'h58 && !r[2]))) n = 0;
      xfer(da, r[2], r[23:16], n, (n == 1 && r[3]) ? 8'h00 : n[7:0]);
    end
    // Abort a byte by a start, then by a stop, on the second link.
    @(negedge clk_i);
    cond2(1'b1);
    bit2(1'b1, 1'b0);
    bit2(1'b0, 1'b0);
    cond2(1'b1);
    addr2();
    bit2(1'b0, 1'b0);
    bit2(1'b1, 1'b0);
    cond2(1'b0);
    chk_bit(link2.dev_sda_oe, 1'b0, "released");
    cond2(1'b1);
    addr2();
    cond2(1'b0);
    repeat (50) @(negedge clk_i);
    chk_bit(wq.size() == 0 && rq.size() == 0, 1'b1, "leftover");
    conclude();
  end
endmodule
